/* rtl/dds_top.sv */
// disk data sequencer: microword store, branch logic and disk side orders
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - command picks page, spares 1, 3 pick page 0; origin page times 0x40
// - test result forms lowest next address bit
// - test code 0 is always true, 1-6 pick disk conditions
// - codes 7-F pick counter thresholds, carry
// - two-bit read and write data selects
// - order field issues error enables, done
// - bits 14,15,17: command clear, count, ecc clear
// - bits 16,18-21: ecc, crc, compare, fifo
// - bits 22,23 drive write and read gates
// - 512 by 24 store, command gives page
// - microword gives pair, two-way branch
module dds_top (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // store loading port for the microprogram
    input wire logic load_we_i,
    input wire logic [8:0] load_addr_i,
    input wire logic [23:0] load_data_i,
    // disk side conditions, asynchronous pins
    input wire logic hdr_error_i,
    input wire logic index_sector_mark_i,
    input wire logic sync_n_i,
    input wire logic check_fault_i,
    input wire logic check_inhibit_i,
    input wire logic ecc_end_i,
    // data sources
    input wire logic disk_data_i,
    input wire logic crc_generator_out_i,
    input wire logic ecc_bit_zero_i,
    input wire logic fifo_data_i,
    // data path
    output logic read_data_o,
    output logic write_data_o,
    // orders
    output dds_pkg::dds_order_s order_o,
    output logic ecc_correct_cycle_en_o,
    output logic ecc_crc_clear_o,
    output logic crc_gen_en_o,
    output logic hdr_compare_en_o,
    output logic fifo_drain_en_o,
    output logic fifo_fill_en_o,
    output logic disk_write_gate_o,
    output logic disk_read_gate_o
);
    // ==========================================
    // microword store
    // plain array so a test can load any program; contents are unknown until loaded
    logic [dds_pkg::WORD_BITS-1:0] store [0:dds_pkg::STORE_WORDS-1];
    dds_pkg::dds_uword_s uword; // current microinstruction register
    logic [8:0] addr; // address of the current word
    logic [2:0] command; // from the command register

    // ==========================================
    // pin synchronisers: two flops, first read by the second only
    dds_pkg::dds_cond_s cond_meta;
    dds_pkg::dds_cond_s cond;
    logic [3:0] dsrc_meta;
    logic [3:0] dsrc; // disk, crc, ecc, fifo bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cond_meta <= '0;
            cond <= '0;
            dsrc_meta <= 4'h0;
            dsrc <= 4'h0;
        end else begin
            cond_meta <= {hdr_error_i, index_sector_mark_i, sync_n_i, check_fault_i, check_inhibit_i, ecc_end_i};
            cond <= cond_meta;
            dsrc_meta <= {fifo_data_i, ecc_bit_zero_i, crc_generator_out_i, disk_data_i};
            dsrc <= dsrc_meta;
        end
    end

    // ==========================================
    // counter threshold test
    logic cnt_hit;
    dds_counter u_counter (
        .clk_i,
        .rst_i,
        .clear_i(uword.ecc_crc_clear | ~uword.state_counter_en),
        .count_en_i(uword.state_counter_en),
        .test_i(uword.test),
        .hit_o(cnt_hit)
    );

    // ==========================================
    // test select
    logic test_result;
    always_comb begin
        case (uword.test)
            dds_pkg::TST_TRUE: test_result = 1'b1;
            dds_pkg::TST_HDR_ERR: test_result = cond.hdr_error;
            dds_pkg::TST_MARK: test_result = cond.index_sector_mark;
            dds_pkg::TST_SYNC_N: test_result = cond.sync_n;
            dds_pkg::TST_CHECK: test_result = cond.check_fault;
            dds_pkg::TST_INHIBIT: test_result = cond.check_inhibit;
            dds_pkg::TST_ECC_END: test_result = cond.ecc_end;
            default: test_result = cnt_hit;
        endcase
    end

    // ==========================================
    // next address: page, pair from the word, test bit appended
    function automatic logic [8:0] page_origin(input logic [2:0] cmd);
        page_origin = 9'({cmd, 6'h00});
    endfunction
    // spare pages 1 and 3 are steered to idle so stray programs cannot run
    wire spare_cmd = (command == dds_pkg::CMD_SPARE1) | (command == dds_pkg::CMD_SPARE3);
    wire [2:0] page = spare_cmd ? dds_pkg::CMD_IDLE : command;
    wire [8:0] next_addr = page_origin(page) | {3'h0, uword.state, test_result};

    // ==========================================
    // sequencer step: one word per clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr <= 9'h000;
            uword <= '0;
        end else begin
            addr <= next_addr;
            uword <= store[next_addr];
        end
    end
    always_ff @(posedge clk_i) begin
        if (load_we_i) begin
            store[load_addr_i] <= load_data_i;
        end
    end

    // ==========================================
    // data path selects: the select code indexes the sources, zero fill at 0
    wire [3:0] read_pick = {dsrc[3], dsrc[2], dsrc[0], 1'b0};
    wire [3:0] write_pick = {dsrc[3], dsrc[2], dsrc[1], 1'b0};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_data_o <= 1'b0;
            write_data_o <= 1'b0;
        end else begin
            read_data_o <= read_pick[uword.select];
            write_data_o <= write_pick[uword.select];
        end
    end

    // ==========================================
    // order decode, spare codes yield nothing
    dds_pkg::dds_order_s next_order;
    always_comb begin
        next_order = '0;
        case (uword.order)
            dds_pkg::ORD_NOP: next_order = '0;
            dds_pkg::ORD_CHECK_EN: next_order.check_error_en = 1'b1;
            dds_pkg::ORD_CRC_EN: next_order.crc_error_en = 1'b1;
            dds_pkg::ORD_BAD_SECT_EN: next_order.bad_sector_error_en = 1'b1;
            dds_pkg::ORD_FORMAT_EN: next_order.format_error_en = 1'b1;
            dds_pkg::ORD_DONE: next_order.done = 1'b1;
            default: next_order = '0;
        endcase
    end

    // ==========================================
    // bit orders follow the current word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            order_o <= '0;
            ecc_correct_cycle_en_o <= 1'b0;
            ecc_crc_clear_o <= 1'b0;
            crc_gen_en_o <= 1'b0;
            hdr_compare_en_o <= 1'b0;
            fifo_drain_en_o <= 1'b0;
            fifo_fill_en_o <= 1'b0;
            disk_write_gate_o <= 1'b0;
            disk_read_gate_o <= 1'b0;
        end else begin
            order_o <= next_order;
            ecc_correct_cycle_en_o <= uword.ecc_correct_cycle_en;
            ecc_crc_clear_o <= uword.ecc_crc_clear;
            crc_gen_en_o <= uword.crc_gen_en;
            hdr_compare_en_o <= uword.hdr_compare_en;
            fifo_drain_en_o <= uword.fifo_drain_en;
            fifo_fill_en_o <= uword.fifo_fill_en;
            disk_write_gate_o <= uword.write_gate;
            disk_read_gate_o <= uword.read_gate;
        end
    end

    // ==========================================
    // registers: command, sticky events, mask, state view
    wire [dds_pkg::EV_BITS-1:0] events = {uword.command_reg_clear, next_order.done,
        next_order.format_error_en, next_order.bad_sector_error_en,
        next_order.crc_error_en, next_order.check_error_en};
    dds_wb_regs u_regs (
        .clk_i,
        .rst_i,
        .wb_cyc_i,
        .wb_stb_i,
        .wb_we_i,
        .wb_adr_i,
        .wb_sel_i,
        .wb_dat_i,
        .wb_dat_o,
        .wb_ack_o,
        .event_i(events),
        .cmd_clear_i(uword.command_reg_clear),
        .live_i({uword.read_gate, uword.write_gate, test_result, cnt_hit, 3'h0, addr}),
        .command_o(command),
        .irq_o
    );
endmodule
`default_nettype wire

/* rtl/dds_pkg.sv */
// package of constants and types for the disk data sequencer
package dds_pkg;
    // ==========================================
    // register map (word offsets as byte addresses)
    localparam logic [3:0] ADDR_COMMAND = 4'h0; // command page register
    localparam logic [3:0] ADDR_STATUS = 4'h4; // sticky event bits, read clears
    localparam logic [3:0] ADDR_MASK = 4'h8; // interrupt mask
    localparam logic [3:0] ADDR_STATE = 4'hc; // current rom address and live outputs
    localparam logic [2:0] RESET_COMMAND = 3'h0;
    localparam logic [5:0] RESET_MASK = 6'h00;
    // ==========================================
    // store geometry
    localparam int STORE_WORDS = 512;
    localparam int WORD_BITS = 24;
    localparam logic [8:0] PAGE_STRIDE = 9'h040; // page origin = page * 0x40; spare commands 1 and 3 take page 0
    // ==========================================
    // command pages
    localparam logic [2:0] CMD_IDLE = 3'h0;
    localparam logic [2:0] CMD_SPARE1 = 3'h1;
    localparam logic [2:0] CMD_TEST = 3'h2;
    localparam logic [2:0] CMD_SPARE3 = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_WRITE_HDR = 3'h5;
    localparam logic [2:0] CMD_READ = 3'h6;
    localparam logic [2:0] CMD_READ_HDR = 3'h7;
    // ==========================================
    // test codes
    localparam logic [3:0] TST_TRUE = 4'h0;
    localparam logic [3:0] TST_HDR_ERR = 4'h1;
    localparam logic [3:0] TST_MARK = 4'h2;
    localparam logic [3:0] TST_SYNC_N = 4'h3;
    localparam logic [3:0] TST_CHECK = 4'h4;
    localparam logic [3:0] TST_INHIBIT = 4'h5;
    localparam logic [3:0] TST_ECC_END = 4'h6;
    localparam logic [3:0] TST_CNT_FIRST = 4'h7;
    localparam logic [3:0] TST_CARRY = 4'hf;
    // ==========================================
    // data path selects
    localparam logic [1:0] SEL_ZERO = 2'h0;
    localparam logic [1:0] SEL_DISK = 2'h1; // read: disk data, write: crc out
    localparam logic [1:0] SEL_ECC = 2'h2;
    localparam logic [1:0] SEL_FIFO = 2'h3;
    // ==========================================
    // order codes
    localparam logic [2:0] ORD_NOP = 3'h0;
    localparam logic [2:0] ORD_CHECK_EN = 3'h1;
    localparam logic [2:0] ORD_CRC_EN = 3'h2;
    localparam logic [2:0] ORD_BAD_SECT_EN = 3'h3;
    localparam logic [2:0] ORD_FORMAT_EN = 3'h4;
    localparam logic [2:0] ORD_DONE = 3'h5;
    // ==========================================
    // microword bit positions
    localparam int BIT_CMD_CLEAR = 14;
    localparam int BIT_CNT_EN = 15;
    localparam int BIT_ECC_CORR = 16;
    localparam int BIT_ECC_CLEAR = 17;
    localparam int BIT_CRC_GEN = 18;
    localparam int BIT_HDR_CMP = 19;
    localparam int BIT_FIFO_DRAIN = 20;
    localparam int BIT_FIFO_FILL = 21;
    localparam int BIT_WRITE_GATE = 22;
    localparam int BIT_READ_GATE = 23;
    // status bit positions
    localparam int EV_CHECK = 0;
    localparam int EV_CRC = 1;
    localparam int EV_BAD_SECT = 2;
    localparam int EV_FORMAT = 3;
    localparam int EV_DONE = 4;
    localparam int EV_CMD_CLEAR = 5;
    localparam int EV_BITS = 6;

    // microword layout, msb first
    typedef struct packed {
        logic read_gate;
        logic write_gate;
        logic fifo_fill_en;
        logic fifo_drain_en;
        logic hdr_compare_en;
        logic crc_gen_en;
        logic ecc_crc_clear;
        logic ecc_correct_cycle_en;
        logic state_counter_en;
        logic command_reg_clear;
        logic [2:0] order;
        logic [1:0] select;
        logic [3:0] test;
        logic [4:0] state;
    } dds_uword_s;

    // disk side condition inputs
    typedef struct packed {
        logic hdr_error;
        logic index_sector_mark;
        logic sync_n;
        logic check_fault;
        logic check_inhibit;
        logic ecc_end;
    } dds_cond_s;

    // error enable and done orders
    typedef struct packed {
        logic check_error_en;
        logic crc_error_en;
        logic bad_sector_error_en;
        logic format_error_en;
        logic done;
    } dds_order_s;
endpackage

/* rtl/dds_counter.sv */
// state counter with threshold taps for the disk data sequencer
`timescale 1ns/100ps
`default_nettype none
module dds_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i, // restart counting
    input wire logic count_en_i, // advance one per clock
    input wire logic [3:0] test_i, // selected test code
    output logic hit_o // selected threshold reached
);
    // ==========================================
    // counter
    logic [16:0] count; // bit 16 holds the carry out of 16 bits
    logic [16:0] next_count;
    assign next_count = clear_i ? 17'h00000 : (count_en_i ? count + 17'h00001 : count);

    // one bit taps: reaching 2^n sets bit n; the tap stays set until clear
    logic [16:0] seen;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 17'h00000;
            seen <= 17'h00000;
        end else begin
            count <= next_count;
            seen <= clear_i ? 17'h00000 : (seen | next_count);
        end
    end

    // ==========================================
    // tap select
    always_comb begin
        case (test_i)
            4'h7: hit_o = seen[2];
            4'h8: hit_o = seen[3];
            4'h9: hit_o = seen[4];
            4'ha: hit_o = seen[5];
            4'hb: hit_o = seen[6];
            4'hc: hit_o = seen[7];
            4'hd: hit_o = seen[8];
            4'he: hit_o = seen[12];
            4'hf: hit_o = seen[16];
            default: hit_o = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

/* rtl/dds_wb_regs.sv */
// wishbone register file with sticky status and mask for the sequencer
`timescale 1ns/100ps
`default_nettype none
module dds_wb_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [dds_pkg::EV_BITS-1:0] event_i, // event levels, high for each cycle the current word orders them
    input wire logic cmd_clear_i, // sequencer clears the command
    input wire logic [15:0] live_i, // state view
    output logic [2:0] command_o,
    output logic irq_o
);
    // ==========================================
    // decode
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i & wb_sel_i[0];
    wire rd = req & ~wb_we_i;
    wire hit_cmd = wb_adr_i == dds_pkg::ADDR_COMMAND;
    wire hit_stat = wb_adr_i == dds_pkg::ADDR_STATUS;
    wire hit_mask = wb_adr_i == dds_pkg::ADDR_MASK;
    wire hit_state = wb_adr_i == dds_pkg::ADDR_STATE;

    logic [dds_pkg::EV_BITS-1:0] status;
    logic [dds_pkg::EV_BITS-1:0] mask;
    // a new event beats the clear of a status read in the same cycle
    wire [dds_pkg::EV_BITS-1:0] next_status = ((rd & hit_stat) ? '0 : status) | event_i;
    // ==========================================
    // registers; sequencer clear wins over software write of command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            command_o <= dds_pkg::RESET_COMMAND;
            mask <= dds_pkg::RESET_MASK;
            status <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            status <= next_status;
            if (cmd_clear_i) begin
                command_o <= dds_pkg::CMD_IDLE;
            end else if (wr & hit_cmd) begin
                command_o <= wb_dat_i[2:0];
            end
            if (wr & hit_mask) begin
                mask <= wb_dat_i[dds_pkg::EV_BITS-1:0];
            end
            if (rd) begin
                // unmapped addresses read zero and are acked
                wb_dat_o <= hit_cmd ? {29'h0, command_o} :
                            hit_stat ? {26'h0, status} :
                            hit_mask ? {26'h0, mask} :
                            hit_state ? {16'h0, live_i} : 32'h00000000;
            end
        end
    end
    assign irq_o = |(status & mask);
endmodule
`default_nettype wire

/* test/dds_top_props.sv */
// concurrent checks on the ports of the disk data sequencer
`timescale 1ns/100ps
`default_nettype none
module dds_top_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire dds_pkg::dds_order_s order_o,
    input wire logic disk_write_gate_o,
    input wire logic disk_read_gate_o
);
    // ==========================================
    // one clock domain, so one default clock and disable
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request the slave has not yet answered
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd_req = req && !wb_we_i;

    a_ack_after_req: assert property (req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_needs_req: assert property (!req |=> !wb_ack_o)
        else $error("ack without a pending request");
    // reset quietens ack, interrupt, orders and both gates
    a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> (!wb_ack_o && !irq_o && order_o == '0 && !disk_write_gate_o && !disk_read_gate_o))
        else $error("outputs active after reset edge");
    a_order_onehot: assert property ($onehot0(order_o))
        else $error("more than one order active");
    a_irq_mask_off: assert property ((req && wb_we_i && wb_sel_i[0] && wb_adr_i == dds_pkg::ADDR_MASK
        && wb_dat_i[5:0] == 6'h00) |=> !irq_o)
        else $error("interrupt high with all sources masked");
    a_command_width: assert property ((rd_req && wb_adr_i == dds_pkg::ADDR_COMMAND)
        |=> wb_dat_o[31:3] == 29'h0)
        else $error("command read wider than three bits");
    a_gate_view: assert property ((rd_req && wb_adr_i == dds_pkg::ADDR_STATE)
        |=> (wb_dat_o[14] == disk_write_gate_o && wb_dat_o[15] == disk_read_gate_o))
        else $error("state view disagrees with gate outputs");
    a_unmapped_zero: assert property ((rd_req && wb_adr_i[1:0] != 2'h0) |=> wb_dat_o == 32'h0)
        else $error("unmapped read returned data");
endmodule
bind dds_top dds_top_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .order_o, .disk_write_gate_o, .disk_read_gate_o);
`default_nettype wire

/* test/dds_disk_model.sv */
// behavioural disk drive facing the sequencer's read gate and condition pins
`timescale 1ns/100ps
`default_nettype none
module dds_disk_model (
    input wire logic clk_i,
    input wire logic read_gate_i, // head reading when high
    input wire logic data_i, // bit under the head
    input wire logic [5:0] cond_i, // drive status levels asked by the bench
    output logic disk_data_o,
    output logic [5:0] cond_o
);
    // ==========================================
    // drive side, changes just after each edge
    initial disk_data_o = 1'b0;
    initial cond_o = 6'h00;
    always @(posedge clk_i) begin
        cond_o <= cond_i;
        if (read_gate_i) begin
            disk_data_o <= data_i;
        end else begin
            // no data off the head: toggle so stale bits fail
            disk_data_o <= ~disk_data_o;
        end
    end
endmodule
`default_nettype wire

/* test/test_dds_top.sv */
// self-checking bench for the disk data sequencer
`timescale 1ns/100ps
`default_nettype none
module test_dds_top;
    // ==========================================
    // stimulus and bookkeeping
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0;
    logic ld_we = 1'b0;
    logic [8:0] ld_a = 9'h000;
    logic [23:0] ld_d = 24'h000000;
    logic [5:0] cond = 6'h00; // wanted drive levels
    logic [3:0] src = 4'h0; // {disk, crc, ecc, fifo} source bits
    logic snap = 1'b0;
    logic [31:0] rnd = 32'd43955;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [63:0] rdq[$]; // {mask, expected} per read
    logic [15:0] outq[$];
    wire [31:0] wb_dat_o;
    wire wb_ack_o, irq_o, rd_o, wr_o, ecc_o, clr_o, crc_o, hdr_o, drn_o, fil_o, wg_o, rg_o, dsk;
    wire [5:0] mc;
    dds_pkg::dds_order_s order_o;
    wire [15:0] vec = {rd_o, wr_o, order_o, ecc_o, clr_o, crc_o, hdr_o, drn_o, fil_o, wg_o, rg_o, irq_o};
    dds_top dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .irq_o,
        .load_we_i(ld_we), .load_addr_i(ld_a), .load_data_i(ld_d), .hdr_error_i(mc[5]),
        .index_sector_mark_i(mc[4]), .sync_n_i(mc[3]), .check_fault_i(mc[2]), .check_inhibit_i(mc[1]),
        .ecc_end_i(mc[0]), .disk_data_i(dsk), .crc_generator_out_i(src[2]), .ecc_bit_zero_i(src[1]),
        .fifo_data_i(src[0]), .read_data_o(rd_o), .write_data_o(wr_o), .order_o,
        .ecc_correct_cycle_en_o(ecc_o), .ecc_crc_clear_o(clr_o), .crc_gen_en_o(crc_o),
        .hdr_compare_en_o(hdr_o), .fifo_drain_en_o(drn_o), .fifo_fill_en_o(fil_o),
        .disk_write_gate_o(wg_o), .disk_read_gate_o(rg_o));
    dds_disk_model drive (.clk_i, .read_gate_i(rg_o), .data_i(src[3]), .cond_i(cond),
        .disk_data_o(dsk), .cond_o(mc));
    always #5 clk_i = ~clk_i;
    // ==========================================
    // helpers
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    // microword from bit orders, order, select, test and next pair
    function automatic logic [23:0] uw(input logic [9:0] b, input logic [2:0] o, input logic [1:0] s,
        input logic [3:0] t, input logic [4:0] st);
        return {b, o, s, t, st};
    endfunction
    // expected port picture for a word held steady
    function automatic logic [15:0] eo(input logic [23:0] w, input logic irq);
        logic [3:0] rs, ws;
        logic [4:0] od;
        rs = {src[0], src[1], src[3], 1'b0}; // fifo, ecc, disk, zero
        ws = {src[0], src[1], src[2], 1'b0}; // fifo, ecc, crc, zero
        od = (w[13:11] >= 3'h1 && w[13:11] <= 3'h5) ? (5'h10 >> (w[13:11] - 3'h1)) : 5'h00;
        return {rs[w[10:9]], ws[w[10:9]], od, w[16], w[17], w[18], w[19], w[20], w[21], w[22], w[23], irq};
    endfunction
    task automatic ld(input logic [8:0] a, input logic [23:0] d);
        ld_we <= 1'b1;
        ld_a <= a;
        ld_d <= d;
        @(posedge clk_i);
        ld_we <= 1'b0;
        @(posedge clk_i);
    endtask
    // classic single cycle; a read notes its expectation first
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
        int n = 0;
        if (!w) rdq.push_back({m, d});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= w ? d : 32'h0;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) n_mismatch++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic chk(input logic [15:0] e);
        outq.push_back(e);
        snap <= 1'b1;
        @(posedge clk_i);
        snap <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // park at pair 1, arm words 4 and 5, then leave through word 3
    task automatic br(input logic [23:0] w3, input logic [23:0] w4, input int wt, input logic [8:0] ea,
        input logic [31:0] m);
        for (int a = 3; a < 6; a++) ld(9'(a), 24'h000001);
        repeat (6) @(posedge clk_i);
        ld(9'h004, w4);
        ld(9'h005, 24'h000002);
        ld(9'h003, w3);
        repeat (wt) @(posedge clk_i);
        wb(1'b0, dds_pkg::ADDR_STATE, {23'h0, ea}, m);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==========================================
    // result watcher: oldest note against what appears
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && cyc && !we && rdq.size() > 0) begin
            if (rdq[0][63:32] != 32'h0) cmp(wb_dat_o & rdq[0][63:32], rdq[0][31:0]);
            void'(rdq.pop_front());
        end
        if (snap === 1'b1 && outq.size() > 0) cmp({16'h0, vec}, {16'h0, outq.pop_front()});
    end
    // hang guard sized for the longest counter wait
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            n_mismatch++;
            conclude();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        logic [23:0] w;
        int t;
        @(posedge clk_i);
        // every pair loops on its odd word, so each page settles at origin plus one
        for (int a = 0; a < 512; a++) ld(9'(a), uw(10'h0, 3'h0, 2'h0, dds_pkg::TST_TRUE, 5'(a >> 1)));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, dds_pkg::ADDR_COMMAND, 32'h0, 32'h7);
        wb(1'b0, dds_pkg::ADDR_MASK, 32'h0, 32'h3f);
        wb(1'b0, 4'h2, 32'h0, 32'hffffffff);
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, dds_pkg::ADDR_COMMAND, 32'(i), 32'h0);
            repeat (6) @(posedge clk_i);
            wb(1'b0, dds_pkg::ADDR_COMMAND, 32'(i), 32'h7);
            wb(1'b0, dds_pkg::ADDR_STATE, (i == 1 || i == 3) ? 32'h1 : 32'(i * 64 + 1), 32'h1ff);
        end
        ld(9'h081, uw(10'h001, 3'h0, 2'h0, dds_pkg::TST_TRUE, 5'h00));
        wb(1'b1, dds_pkg::ADDR_COMMAND, 32'h2, 32'h0);
        repeat (8) @(posedge clk_i);
        wb(1'b0, dds_pkg::ADDR_COMMAND, 32'h0, 32'h7);
        wb(1'b0, dds_pkg::ADDR_STATE, 32'h1, 32'h1ff);
        wb(1'b0, dds_pkg::ADDR_STATUS, 32'h20, 32'h20);
        $display("test pages done");
        // every order and select code with random bit orders and sources
        for (int i = 0; i < 16; i++) begin
            w = uw(10'(xs()) & 10'h3fc | ((i >> 2 == 1) ? 10'h200 : 10'h0), 3'(i), 2'(i >> 2), 4'h0, 5'h0);
            src <= 4'(xs());
            ld(9'h001, w);
            repeat (12) @(posedge clk_i);
            chk(eo(w, 1'b0));
        end
        $display("test orders done");
        w = 24'h000000;
        ld(9'h001, w);
        repeat (6) @(posedge clk_i);
        wb(1'b0, dds_pkg::ADDR_STATUS, 32'h0, 32'h0);
        ld(9'h001, 24'h002800); // done order
        repeat (4) @(posedge clk_i);
        ld(9'h001, w);
        repeat (6) @(posedge clk_i);
        wb(1'b1, dds_pkg::ADDR_MASK, 32'h01, 32'h0);
        chk(eo(w, 1'b0));
        wb(1'b1, dds_pkg::ADDR_MASK, 32'h10, 32'h0);
        chk(eo(w, 1'b1));
        wb(1'b0, dds_pkg::ADDR_MASK, 32'h10, 32'h3f);
        wb(1'b0, dds_pkg::ADDR_STATUS, 32'h10, 32'h3f);
        chk(eo(w, 1'b0));
        wb(1'b1, dds_pkg::ADDR_MASK, 32'h00, 32'h0);
        $display("test interrupt done");
        // branch on each disk condition, both levels, others held opposite
        ld(9'h001, 24'h000001);
        for (int c = 1; c < 7; c++) begin
            for (int v = 0; v < 2; v++) begin
                cond <= (v == 1) ? (6'h20 >> (c - 1)) : ~(6'h20 >> (c - 1));
                br(uw(10'h0, 3'h0, 2'h0, 4'(c), 5'h02), 24'h0000e2, 10,
                    9'(4 + v), 32'h1ff);
            end
        end
        br(24'h000002, 24'h0000e2, 10, 9'h005, 32'h1ff);
        $display("test conditions done");
        cond <= 6'h00;
        for (int k = 0; k < 9; k++) begin
            t = (k == 8) ? 65536 : (k == 7) ? 4096 : (4 << k);
            br(24'h000022, uw(10'h002, 3'h0, 2'h0, 4'(7 + k), 5'h02),
                t / 2, 9'h004, (t >= 16) ? 32'h1ff : 32'h0);
            repeat (t / 2 + 12) @(posedge clk_i);
            wb(1'b0, dds_pkg::ADDR_STATE, 32'h5, 32'h1ff);
        end
        $display("test counter done");
        conclude();
    end
endmodule
`default_nettype wire
